// ### inc/fault_regs_pkg.sv
package fault_regs_pkg;
  // Register addresses on the control port (8-bit register index)
  localparam logic [7:0] fault_addr       = 8'h08;
  localparam logic [7:0] clip_middle_addr = 8'h10;
  localparam logic [7:0] clip_low_addr    = 8'h11;
  localparam logic [7:0] reserved_lo_addr = 8'h09;
  localparam logic [7:0] reserved_hi_addr = 8'h0f;
  // Field positions in the fault register
  localparam int trip_sel_lsb  = 4;
  localparam int clk_err_bit   = 3;
  localparam int oc_err_bit    = 2;
  localparam int dc_err_bit    = 1;
  localparam int ot_err_bit    = 0;
  // Reset values
  localparam logic [1:0] trip_sel_reset    = 2'h0;
  localparam logic [7:0] clip_middle_reset = 8'h01;
  localparam logic [7:0] clip_low_reset    = 8'h04;
  localparam logic [5:0] clip_upper_reset  = 6'h00;
  // Trip level in quarters of nominal
  localparam logic [2:0] trip_full    = 3'h4;
  localparam logic [2:0] trip_3q      = 3'h3;
  localparam logic [2:0] trip_half    = 3'h2;
  localparam logic [2:0] trip_quarter = 3'h1;
  // Shutdown pin sampled through three flops
  localparam int sync_depth = 3;

  typedef struct packed {
    logic clk_err;
    logic oc_err;
    logic dc_err;
    logic ot_err;
  } fault_flags_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;
endpackage

// ### hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [fault_regs_pkg::sync_depth-1:0] stage_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[fault_regs_pkg::sync_depth-2:0], pin_in};
    end
  end

  // Level moves only once the last two stages agree; first stage feeds only the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      level_out <= 1'b0;
    end else if (stage_reg[2] == stage_reg[1]) begin
      level_out <= stage_reg[2];
    end
  end
endmodule

// ### hdl/fault_status_clip_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Trip select resets 00; codes scale down
// - Clock error bit 3 is live, unlatched
// - Clock recovery resumes operation without host
// - Overcurrent bit 2 latches, halts until toggle
// - DC offset bit 1 latches, halts until toggle
// - Overtemp bit 0 latches, halts until toggle
// - Fault bits 7:6 read zero, read-only
// - Clip threshold is 20 bits, three fields
// - Address 0x10 holds threshold bits 13:6
// - Address 0x11 bits 7:2 hold bits 5:0
module fault_status_clip_regs (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire fault_regs_pkg::reg_access_t acc,
  output logic [7:0]                       rdata,
  input  wire logic                        speaker_shutdown_n,
  input  wire logic                        sd_ctrl_bit,
  input  wire logic                        clock_invalid,
  input  wire logic                        overcurrent_detect,
  input  wire logic                        dc_offset_detect,
  input  wire logic                        overtemp_detect,
  input  wire logic [5:0]                  clip_upper_bits,
  output logic [1:0]                       overcurrent_trip_select,
  output logic [2:0]                       trip_level_quarters,
  output logic [19:0]                      clip_threshold_level,
  output fault_regs_pkg::fault_flags_t     flags,
  output logic                             run_enable
);
  // Configuration storage
  logic                         pin_level;
  logic                         sd_active;
  logic [1:0]                   trip_reg;
  logic [7:0]                   mid_reg;
  logic [7:0]                   low_reg;

  // Fault state
  logic                         oc_reg;
  logic                         dc_reg;
  logic                         ot_reg;
  logic                         clk_reg;
  logic                         latched_any;
  logic [2:0]                   detect_vec;
  logic [2:0]                   latch_reg;

  // Next values of the output flops
  logic                         run_next;
  logic [2:0]                   quarters_next;
  logic [19:0]                  clip_next;
  logic [7:0]                   rd_next;
  fault_regs_pkg::fault_flags_t flags_next;

  pin_sync u_sd_sync (
    .mclk      (mclk),
    .rstn      (rstn),
    .pin_in    (speaker_shutdown_n),
    .level_out (pin_level)
  );

  // Shutdown from the pin or the control bit; pin reads low until synced
  assign sd_active   = !pin_level || !sd_ctrl_bit;
  assign latched_any = oc_reg || dc_reg || ot_reg;

  function automatic logic [2:0] trip_decode(input logic [1:0] code);
    case (code)
      2'h0:    trip_decode = fault_regs_pkg::trip_full;
      2'h1:    trip_decode = fault_regs_pkg::trip_3q;
      2'h2:    trip_decode = fault_regs_pkg::trip_half;
      default: trip_decode = fault_regs_pkg::trip_quarter;
    endcase
  endfunction

  // Shared by the write and read decoders so both see one map
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  // Reserved window; the host keeps away, reads give zero anyway
  function automatic logic addr_reserved(input logic [7:0] addr);
    addr_reserved = (addr >= fault_regs_pkg::reserved_lo_addr) &&
                    (addr <= fault_regs_pkg::reserved_hi_addr);
  endfunction

  // Bits 7:6 tied low here, never stored
  function automatic logic [7:0] fault_word(input logic [1:0] trip, input logic [3:0] status);
    fault_word = {2'h0, trip, status};
  endfunction

  // Writable configuration, one register per block
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trip_reg <= fault_regs_pkg::trip_sel_reset;
    end else if (acc.wr && addr_hit(acc.addr, fault_regs_pkg::fault_addr)) begin
      trip_reg <= acc.wdata[fault_regs_pkg::trip_sel_lsb +: 2];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mid_reg <= fault_regs_pkg::clip_middle_reset;
    end else if (acc.wr && addr_hit(acc.addr, fault_regs_pkg::clip_middle_addr)) begin
      mid_reg <= acc.wdata;
    end
  end

  // Reserved bits 1:0 are kept as plain storage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      low_reg <= fault_regs_pkg::clip_low_reset;
    end else if (acc.wr && addr_hit(acc.addr, fault_regs_pkg::clip_low_addr)) begin
      low_reg <= acc.wdata;
    end
  end

  // Latched faults: shutdown clears, but a fresh detect wins over the clear
  assign detect_vec = {overcurrent_detect, dc_offset_detect, overtemp_detect};

  // One latch per fault source except the clock, same clear for all
  for (genvar gi = 0; gi < 3; gi++) begin : g_latch
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        latch_reg[gi] <= 1'b0;
      end else begin
        latch_reg[gi] <= detect_vec[gi] || (latch_reg[gi] && !sd_active);
      end
    end
  end

  assign oc_reg = latch_reg[2];
  assign dc_reg = latch_reg[1];
  assign ot_reg = latch_reg[0];

  // Clock error follows the detector, no latch
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clk_reg <= 1'b0;
    end else begin
      clk_reg <= clock_invalid;
    end
  end

  // Running needs no shutdown, no latched fault, valid clocks
  // Raw detector used so a clock error stops output a cycle sooner
  assign run_next = !sd_active &&
                    !latched_any &&
                    !clock_invalid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_enable <= 1'b0;
    end else begin
      run_enable <= run_next;
    end
  end

  // Next values for the datapath copies
  assign quarters_next = trip_decode(trip_reg);
  assign clip_next     = {clip_upper_bits, mid_reg, low_reg[7:2]};
  assign flags_next    = '{clk_err: clk_reg,
                           oc_err:  oc_reg,
                           dc_err:  dc_reg,
                           ot_err:  ot_reg};

  // Registered copies; every port leaves from a flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      overcurrent_trip_select <= fault_regs_pkg::trip_sel_reset;
    end else begin
      overcurrent_trip_select <= trip_reg;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trip_level_quarters <= fault_regs_pkg::trip_full;
    end else begin
      trip_level_quarters <= quarters_next;
    end
  end

  // Upper bits come from a register held elsewhere, lag of one cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clip_threshold_level <= {fault_regs_pkg::clip_upper_reset, fault_regs_pkg::clip_middle_reset,
                               fault_regs_pkg::clip_low_reset[7:2]};
    end else begin
      clip_threshold_level <= clip_next;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags <= flags_next;
    end
  end

  // Read mux; reserved and unmapped addresses give zero
  always_comb begin
    if (addr_hit(acc.addr, fault_regs_pkg::fault_addr)) begin
      rd_next = fault_word(trip_reg, {clk_reg, oc_reg, dc_reg, ot_reg});
    end else if (addr_hit(acc.addr, fault_regs_pkg::clip_middle_addr)) begin
      rd_next = mid_reg;
    end else if (addr_hit(acc.addr, fault_regs_pkg::clip_low_addr)) begin
      rd_next = low_reg;
    end else if (addr_reserved(acc.addr)) begin
      rd_next = 8'h00;
    end else begin
      rd_next = 8'h00;
    end
  end

  // Registered read costs a cycle but keeps rdata off the address path
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (acc.rd) begin
      rdata <= rd_next;
    end
  end
endmodule

// ### tb/fault_regs_monitor.sv
`timescale 1ns/1ps
module fault_regs_monitor (
  input wire logic                         mclk,
  input wire logic                         rstn,
  input wire logic                         speaker_shutdown_n,
  input wire logic                         sd_ctrl_bit,
  input wire logic                         clock_invalid,
  input wire logic                         overcurrent_detect,
  input wire logic                         dc_offset_detect,
  input wire fault_regs_pkg::reg_access_t  acc,
  input wire logic [7:0]                   rdata,
  input wire logic [1:0]                   overcurrent_trip_select,
  input wire logic [2:0]                   trip_level_quarters,
  input wire logic [19:0]                  clip_threshold_level,
  input wire fault_regs_pkg::fault_flags_t flags
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_clk_live: assert property (1 |-> ##2 flags.clk_err == $past(clock_invalid, 2))
    else $error("clock flag wrong");
  a_oc_set: assert property (overcurrent_detect |-> ##2 flags.oc_err)
    else $error("overcurrent not set");
  // Seven cycles covers the pin synchroniser lag
  a_latch_hold: assert property ((speaker_shutdown_n && sd_ctrl_bit)[*7] ##0 flags.oc_err |=> flags.oc_err)
    else $error("latch lost");
  a_latch_clear: assert property ((!sd_ctrl_bit && !dc_offset_detect)[*4] |=> !flags.dc_err)
    else $error("latch not cleared");
  a_trip_scale: assert property ($stable(overcurrent_trip_select) |=> trip_level_quarters ==
    3'h4 - 3'(overcurrent_trip_select)) else $error("trip scale");
  // Field lands at the write edge, port copy one edge later
  a_trip_write: assert property (acc.wr && acc.addr == 8'h08 |-> ##2
    overcurrent_trip_select == $past(acc.wdata[5:4], 2)) else $error("trip write");
  a_clip_mid: assert property (acc.wr && acc.addr == 8'h10 ##1 !acc.wr |-> ##1
    clip_threshold_level[13:6] == $past(acc.wdata, 2)) else $error("clip middle");
  a_rsvd_zero: assert property (acc.rd && !(acc.addr inside {8'h08, 8'h10, 8'h11}) |=> rdata == 8'h00)
    else $error("reserved read");
endmodule
bind fault_status_clip_regs fault_regs_monitor mon (.mclk(mclk), .rstn(rstn), .speaker_shutdown_n(speaker_shutdown_n),
  .sd_ctrl_bit(sd_ctrl_bit), .clock_invalid(clock_invalid), .overcurrent_detect(overcurrent_detect),
  .dc_offset_detect(dc_offset_detect), .acc(acc), .rdata(rdata), .overcurrent_trip_select(overcurrent_trip_select),
  .trip_level_quarters(trip_level_quarters), .clip_threshold_level(clip_threshold_level), .flags(flags));

// ### tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic                  mclk,
  output fault_regs_pkg::reg_access_t acc
);
  initial acc = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    acc <= '{wr: w, rd: !w, addr: a, wdata: (a == 8'h08) ? d & 8'h3f : d};
    @(posedge mclk);
    // Idle bus shows inverted data, never stale values
    acc <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
  endtask
endmodule

// ### tb/fault_status_clip_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED %0t %h", $time, a); end end
module fault_status_clip_regs_tb_top;
  logic mclk = 0, rstn = 0, pin_n = 0, sd = 0, ckb = 0, run;
  logic [2:0] det = '0;
  logic [5:0] up = '0;
  logic [7:0] rdata, m, l, a;
  logic [2:0] q;
  logic [19:0] clip;
  logic [31:0] seed = 62;
  fault_regs_pkg::fault_flags_t flags;
  fault_regs_pkg::reg_access_t acc;
  int n_fail = 0, tests_run = 0;
  host_model host (.mclk(mclk), .acc(acc));
  fault_status_clip_regs uut (.mclk(mclk), .rstn(rstn), .acc(acc), .rdata(rdata), .speaker_shutdown_n(pin_n),
    .sd_ctrl_bit(sd), .clock_invalid(ckb), .overcurrent_detect(det[2]), .dc_offset_detect(det[1]),
    .overtemp_detect(det[0]), .clip_upper_bits(up), .overcurrent_trip_select(), .trip_level_quarters(q),
    .clip_threshold_level(clip), .flags(flags), .run_enable(run));
  initial forever #12.5 mclk = ~mclk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [19:0] clip_exp(input logic [5:0] u, input logic [7:0] mm, input logic [7:0] ll);
    return {u, mm, ll[7:2]};
  endfunction
  task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
    host.xfer(0, ad, 8'h00);
    `CHK(rdata, e)
  endtask
  task automatic set_sd(input logic v);
    @(posedge mclk) pin_n <= v;
    sd <= v;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic wait_run();
    for (int i = 0; i < 20 && run !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    `CHK(run, 1'b1)
    if (run !== 1'b1) conclude();
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1;
    rdc(8'h08, 8'h00);
    rdc(8'h11, 8'h04);
    `CHK(clip, clip_exp(6'h00, 8'h01, 8'h04))
    for (int c = 0; c < 4; c++) begin
      a = rnd();
      host.xfer(1, 8'h08, {a[7:6], 2'(c), a[3:0]});
      rdc(8'h08, {2'h0, 2'(c), 4'h0});
      `CHK(q, 3'(4 - c))
    end
    for (int k = 0; k < 8; k++) begin
      m = rnd();
      l = rnd() & 8'hfc;
      @(posedge mclk) up <= m[5:0] ^ l[5:0];
      host.xfer(1, 8'h10, m);
      host.xfer(1, 8'h11, l);
      rdc(8'h10, m);
      rdc(8'h11, l);
      `CHK(clip, clip_exp(m[5:0] ^ l[5:0], m, l))
    end
    // Host keeps out of the reserved window; unmapped addresses above it
    for (int ad = 8'h12; ad < 8'h19; ad++) begin
      host.xfer(1, 8'(ad), rnd());
      rdc(8'(ad), 8'h00);
    end
    $display("test registers done");
    set_sd(1);
    wait_run();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) det <= 3'(1 << i);
      @(posedge mclk) det <= 3'h0;
      repeat (6) @(posedge mclk);
      rdc(8'h08, {4'h3, 1'b0, 3'(1 << i)});
      `CHK(run, 1'b0)
      set_sd(0);
      `CHK(flags, 4'h0)
      set_sd(1);
      wait_run();
    end
    @(posedge mclk) ckb <= 1;
    repeat (4) @(posedge mclk);
    #1;
    `CHK(flags, 4'h8)
    `CHK(run, 1'b0)
    @(posedge mclk) ckb <= 0;
    wait_run();
    @(posedge mclk);
    #1;
    `CHK(flags, 4'h0)
    $display("test faults done");
    conclude();
  end
endmodule
